/* File: uart_rx_defs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the serial receive filter.
// Assumes: Register port carries 8-bit addresses and 8-bit data.
// Notes: Offsets 0x98, 0xA9, 0xB9 are the special function register addresses; the others are local.
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_POWER_CONTROL 8'h87
`define OFS_STATION_ADDRESS 8'hA9
`define OFS_ADDRESS_MASK 8'hB9
`define OFS_BAUD_DIV 8'hC0
`define OFS_TX_BAUD_DIV 8'hC5
`define OFS_TX_DATA 8'hC1
`define OFS_RX_DATA 8'hC2
`define OFS_IRQ_STATUS 8'hC3
`define OFS_IRQ_MASK 8'hC4
`define BIT_SC_TOP 7
`define BIT_SC_MODE_LOW 6
`define BIT_SC_MULTIDROP 5
`define BIT_SC_RX_ENABLE 4
`define BIT_SC_TX_NINTH 3
`define BIT_SC_RX_NINTH 2
`define BIT_SC_TX_DONE 1
`define BIT_SC_RX_DONE 0
`define BIT_PC_FRAME_ERR_EN 6
`define BIT_IRQ_RX 0
`define BIT_IRQ_TX 1
`define BIT_IRQ_FE 2
`define RST_BYTE 8'h00
`define RST_BAUD_DIV 16'h000A
`define OVERSAMPLE 16
`endif

/* File: uart_rx_pkg.sv */
// Purpose: Types shared by the serial receive filter.
// Assumes: Used together with uart_rx_defs.svh.
// Notes: States are one-hot.
package uart_rx_pkg;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BITS = 3'b010,
        TX_STOP = 3'b100
    } tx_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : uart_rx_pkg

/* File: uart_rx_filter.sv */
// Purpose: Asynchronous serial port with frame-error check and hardware address filtering.
// Assumes: 20 MHz clk_sys; baud divider gives 16 ticks per bit; rx pin is asynchronous.
// Notes: Mode 0 shift-register operation is not provided; in mode 0 the receiver stays idle.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

// Contract
// R1: Transmit and receive run at once, each with its own baud divider.
// R2: Frame-error checking works in modes 1 to 3 and only while frame_error_enable is set.
// R3: With checking on, each frame's stop bit is tested and a bad one sets frame_error_flag.
// R4: frame_error_flag stays set until software writes it to zero or reset; good frames leave it.
// R5: With checking on, receive_done_flag rises at the stop bit, not at the last data bit.
// R6: Address recognition is on exactly when multidrop_enable is set.
// R7: With recognition on, an address frame raises receive_done_flag only on a given or broadcast match.
// R8: In mode 1 with recognition on, the stop bit is the ninth bit and a match needs a valid stop bit.
// R9: In mode 0 multidrop_enable has no effect.
// R10: The given address compares only the station_address bits whose mask bit is one.
// R11: A mask of all ones compares every bit of the individual address.
// R12: The broadcast address is station_address OR mask, zero bits being don't care.
// R13: Reset clears station_address and mask, so any address is accepted.
// R14: Bit 7 of serial_control_register is frame_error_flag while frame_error_enable is set, else the mode bit.
// R15: In modes 2 and 3 only frames with ninth bit one are address-matched.
module uart_rx_filter #(
    parameter int DIV_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic irq
);
    uart_rx_pkg::reg_req_t req;
    // Register and flag state.
    logic rx_s1_r, rx_s2_r, fe_flag_r, fe_flag_nxt, fe_en_r, fe_en_nxt, irq_r, irq_nxt;
    logic multidrop_r, multidrop_nxt, rx_en_r, rx_en_nxt, tb8_r, tb8_nxt, rb8_r, rb8_nxt;
    logic ti_r, ti_nxt, ri_r, ri_nxt, tx_r, tx_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [2:0] irq_st_r, irq_st_nxt, irq_mk_r, irq_mk_nxt;
    logic [7:0] receive_station_address_r, receive_station_address_nxt, smask_r, smask_nxt, rx_data_r, rx_data_nxt, rdata_r, rdata_nxt;
    logic [DIV_W-1:0] rx_div_r, rx_div_nxt, tx_div_r, tx_div_nxt, rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
    // Receiver and transmitter sequencing state.
    uart_rx_pkg::rx_state_t rs_r, rs_nxt;
    uart_rx_pkg::tx_state_t ts_r, ts_nxt;
    logic [3:0] rtick_r, rtick_nxt, rbit_r, rbit_nxt, ttick_r, ttick_nxt, tbit_r, tbit_nxt;
    logic [8:0] rsh_r, rsh_nxt;
    logic [9:0] tsh_r, tsh_nxt;
    logic rx_tick, tx_tick, rx_mid, ri_set, fe_set, ti_set, ninth_bits;
    logic [7:0] rx_byte, given_care, bcast_addr;
    logic addr_match, stop_ok, accept, ninth;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    // Two-stage synchroniser for the receive pin.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // Independent oversample ticks for each direction.
    assign rx_tick = (rcnt_r == '0); // R1
    assign tx_tick = (tcnt_r == '0); // R1
    assign rx_mid = rx_tick && (rtick_r == 4'(`OVERSAMPLE / 2 - 1));
    assign ninth_bits = mode_r[1];

    // Address match: given compares mask-one bits, broadcast compares OR-one bits.
    assign rx_byte = ninth_bits ? rsh_r[7:0] : rsh_r[8:1];
    assign given_care = smask_r; // R10 R11
    assign bcast_addr = receive_station_address_r | smask_r; // R12
    assign addr_match = (((rx_byte ^ receive_station_address_r) & given_care) == 8'h00)
        || (((rx_byte ^ bcast_addr) & bcast_addr) == 8'h00); // R12 R13
    assign stop_ok = rx_s2_r;
    assign ninth = ninth_bits ? rsh_r[8] : stop_ok; // R8 R15
    // Frame accepted when not filtered; mode 0 never reaches here.
    assign accept = !multidrop_r || (ninth && addr_match && (ninth_bits || stop_ok)); // R6 R7 R8 R15

    // Receiver sequencing and flag events.
    always_comb begin
        rs_nxt = rs_r;
        rcnt_nxt = rx_tick ? rx_div_r : rcnt_r - DIV_W'(1);
        rtick_nxt = rx_tick ? rtick_r + 4'h1 : rtick_r;
        rbit_nxt = rbit_r;
        rsh_nxt = rsh_r;
        rx_data_nxt = rx_data_r;
        rb8_nxt = rb8_r;
        ri_set = 1'b0;
        fe_set = 1'b0;
        case (rs_r)
            uart_rx_pkg::RX_IDLE: begin
                rtick_nxt = 4'h0;
                if (rx_en_r && mode_r != 2'b00 && !rx_s2_r) begin // R9
                    rs_nxt = uart_rx_pkg::RX_START;
                end
            end
            uart_rx_pkg::RX_START: begin
                if (rx_mid) begin
                    rs_nxt = rx_s2_r ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_BITS;
                    rbit_nxt = 4'h0;
                end
            end
            uart_rx_pkg::RX_BITS: begin
                if (rx_mid) begin
                    rsh_nxt = {rx_s2_r, rsh_r[8:1]};
                    rbit_nxt = rbit_r + 4'h1;
                    if (rbit_r == (ninth_bits ? 4'h8 : 4'h7)) begin
                        rs_nxt = uart_rx_pkg::RX_STOP;
                    end
                end
            end
            uart_rx_pkg::RX_STOP: begin
                if (rx_mid) begin
                    rs_nxt = uart_rx_pkg::RX_IDLE;
                    if (accept) begin
                        rx_data_nxt = rx_byte;
                        rb8_nxt = ninth;
                        ri_set = 1'b1; // R5 R7
                    end
                    fe_set = fe_en_r && !stop_ok; // R2 R3
                end
            end
            default: rs_nxt = uart_rx_pkg::RX_IDLE;
        endcase
    end

    // Transmitter sequencing.
    always_comb begin
        ts_nxt = ts_r;
        tcnt_nxt = tx_tick ? tx_div_r : tcnt_r - DIV_W'(1);
        ttick_nxt = tx_tick ? ttick_r + 4'h1 : ttick_r;
        tbit_nxt = tbit_r;
        tsh_nxt = tsh_r;
        tx_nxt = tx_r;
        ti_set = 1'b0;
        case (ts_r)
            uart_rx_pkg::TX_IDLE: begin
                tx_nxt = 1'b1;
                ttick_nxt = 4'h0;
                if (req.wr && req.addr == `OFS_TX_DATA && mode_r != 2'b00) begin
                    tsh_nxt = ninth_bits ? {tb8_r, req.wdata, 1'b0} : {1'b1, req.wdata, 1'b0};
                    tbit_nxt = 4'h0;
                    ts_nxt = uart_rx_pkg::TX_BITS;
                end
            end
            uart_rx_pkg::TX_BITS: begin
                tx_nxt = tsh_r[0];
                if (tx_tick && ttick_r == 4'(`OVERSAMPLE - 1)) begin
                    tsh_nxt = {1'b1, tsh_r[9:1]};
                    tbit_nxt = tbit_r + 4'h1;
                    if (tbit_r == (ninth_bits ? 4'h9 : 4'h8)) begin
                        ts_nxt = uart_rx_pkg::TX_STOP;
                        ti_set = 1'b1;
                    end
                end
            end
            uart_rx_pkg::TX_STOP: begin
                tx_nxt = 1'b1;
                if (tx_tick && ttick_r == 4'(`OVERSAMPLE - 1)) begin
                    ts_nxt = uart_rx_pkg::TX_IDLE;
                end
            end
            default: ts_nxt = uart_rx_pkg::TX_IDLE;
        endcase
    end

    // Register writes, sticky flags with set over clear, and read data.
    always_comb begin
        mode_nxt = mode_r;
        fe_en_nxt = fe_en_r;
        multidrop_nxt = multidrop_r;
        rx_en_nxt = rx_en_r;
        tb8_nxt = tb8_r;
        ti_nxt = ti_r;
        ri_nxt = ri_r;
        fe_flag_nxt = fe_flag_r;
        receive_station_address_nxt = receive_station_address_r;
        smask_nxt = smask_r;
        rx_div_nxt = rx_div_r;
        tx_div_nxt = tx_div_r;
        irq_mk_nxt = irq_mk_r;
        irq_st_nxt = irq_st_r;
        rdata_nxt = 8'h00;
        if (req.wr) begin
            case (req.addr)
                `OFS_SERIAL_CONTROL: begin
                    if (fe_en_r) begin
                        fe_flag_nxt = req.wdata[`BIT_SC_TOP]; // R14 R4
                    end else begin
                        mode_nxt[1] = req.wdata[`BIT_SC_TOP]; // R14
                    end
                    mode_nxt[0] = req.wdata[`BIT_SC_MODE_LOW];
                    multidrop_nxt = req.wdata[`BIT_SC_MULTIDROP];
                    rx_en_nxt = req.wdata[`BIT_SC_RX_ENABLE];
                    tb8_nxt = req.wdata[`BIT_SC_TX_NINTH];
                    ti_nxt = req.wdata[`BIT_SC_TX_DONE];
                    ri_nxt = req.wdata[`BIT_SC_RX_DONE];
                end
                `OFS_POWER_CONTROL: fe_en_nxt = req.wdata[`BIT_PC_FRAME_ERR_EN];
                `OFS_STATION_ADDRESS: receive_station_address_nxt = req.wdata;
                `OFS_ADDRESS_MASK: smask_nxt = req.wdata;
                `OFS_BAUD_DIV: rx_div_nxt = DIV_W'(req.wdata); // R1
                `OFS_TX_BAUD_DIV: tx_div_nxt = DIV_W'(req.wdata); // R1
                `OFS_IRQ_STATUS: irq_st_nxt = irq_st_r & ~req.wdata[2:0];
                `OFS_IRQ_MASK: irq_mk_nxt = req.wdata[2:0];
                default: ;
            endcase
        end
        // Hardware events win over a clear in the same cycle.
        if (ri_set) begin
            ri_nxt = 1'b1;
            irq_st_nxt[`BIT_IRQ_RX] = 1'b1;
        end
        if (ti_set) begin
            ti_nxt = 1'b1;
            irq_st_nxt[`BIT_IRQ_TX] = 1'b1;
        end
        if (fe_set) begin
            fe_flag_nxt = 1'b1; // R3 R4
            irq_st_nxt[`BIT_IRQ_FE] = 1'b1;
        end
        if (req.rd) begin
            case (req.addr)
                `OFS_SERIAL_CONTROL: rdata_nxt = {fe_en_r ? fe_flag_r : mode_r[1], mode_r[0], multidrop_r,
                    rx_en_r, tb8_r, rb8_r, ti_r, ri_r}; // R14
                `OFS_POWER_CONTROL: rdata_nxt = {1'b0, fe_en_r, 6'h00};
                `OFS_STATION_ADDRESS: rdata_nxt = receive_station_address_r;
                `OFS_ADDRESS_MASK: rdata_nxt = smask_r;
                `OFS_BAUD_DIV: rdata_nxt = rx_div_r[7:0];
                `OFS_RX_DATA: rdata_nxt = rx_data_r;
                `OFS_IRQ_STATUS: rdata_nxt = {5'h00, irq_st_r};
                `OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mk_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
        irq_nxt = |(irq_st_nxt & irq_mk_nxt);
    end
    // Register every state group.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r <= 2'b00;
            fe_en_r <= 1'b0;
            fe_flag_r <= 1'b0;
            multidrop_r <= 1'b0;
            rx_en_r <= 1'b0;
            tb8_r <= 1'b0;
            rb8_r <= 1'b0;
            ti_r <= 1'b0;
            ri_r <= 1'b0;
            receive_station_address_r <= `RST_BYTE; // R13
            smask_r <= `RST_BYTE; // R13
            rx_data_r <= `RST_BYTE;
            rx_div_r <= DIV_W'(`RST_BAUD_DIV);
            tx_div_r <= DIV_W'(`RST_BAUD_DIV);
            irq_st_r <= 3'h0;
            irq_mk_r <= 3'h0;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
            rs_r <= uart_rx_pkg::RX_IDLE;
            rcnt_r <= '0;
            rtick_r <= 4'h0;
            rbit_r <= 4'h0;
            rsh_r <= 9'h000;
            ts_r <= uart_rx_pkg::TX_IDLE;
            tcnt_r <= '0;
            ttick_r <= 4'h0;
            tbit_r <= 4'h0;
            tsh_r <= 10'h3FF;
            tx_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            fe_en_r <= fe_en_nxt;
            fe_flag_r <= fe_flag_nxt;
            multidrop_r <= multidrop_nxt;
            rx_en_r <= rx_en_nxt;
            tb8_r <= tb8_nxt;
            rb8_r <= rb8_nxt;
            ti_r <= ti_nxt;
            ri_r <= ri_nxt;
            receive_station_address_r <= receive_station_address_nxt;
            smask_r <= smask_nxt;
            rx_data_r <= rx_data_nxt;
            rx_div_r <= rx_div_nxt;
            tx_div_r <= tx_div_nxt;
            irq_st_r <= irq_st_nxt;
            irq_mk_r <= irq_mk_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            rs_r <= rs_nxt;
            rcnt_r <= rcnt_nxt;
            rtick_r <= rtick_nxt;
            rbit_r <= rbit_nxt;
            rsh_r <= rsh_nxt;
            ts_r <= ts_nxt;
            tcnt_r <= tcnt_nxt;
            ttick_r <= ttick_nxt;
            tbit_r <= tbit_nxt;
            tsh_r <= tsh_nxt;
            tx_r <= tx_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign tx_pin = tx_r;
    assign irq = irq_r;
    // Checks on the flag, receiver, reset and interrupt logic.
    chk_fe_sticky: assert property (@(posedge clk_sys) disable iff (rst) // R4
        fe_flag_r && !(reg_wr && reg_addr == `OFS_SERIAL_CONTROL) |=> fe_flag_r)
        else $error("frame error flag dropped without a write");
    chk_fe_needs_en: assert property (@(posedge clk_sys) disable iff (rst) // R2
        $rose(fe_flag_r) && !$past(reg_wr) |-> $past(fe_en_r))
        else $error("frame error set while checking disabled");
    chk_fe_bad_stop: assert property (@(posedge clk_sys) disable iff (rst) // R3
        rs_r == uart_rx_pkg::RX_STOP && rx_mid && fe_en_r && !rx_s2_r |=> fe_flag_r)
        else $error("bad stop bit not flagged");
    chk_ri_at_stop: assert property (@(posedge clk_sys) disable iff (rst) // R5
        $rose(ri_r) && !$past(reg_wr) |-> $past(rs_r) == uart_rx_pkg::RX_STOP)
        else $error("receive done raised outside stop bit");
    chk_filter_match: assert property (@(posedge clk_sys) disable iff (rst) // R7
        ri_set && multidrop_r |-> addr_match)
        else $error("unmatched address accepted");
    chk_mode1_stop: assert property (@(posedge clk_sys) disable iff (rst) // R8
        ri_set && multidrop_r && mode_r == 2'b01 |-> stop_ok)
        else $error("mode 1 address accepted without stop bit");
    chk_mode0_idle: assert property (@(posedge clk_sys) disable iff (rst) // R9
        mode_r == 2'b00 && rs_r == uart_rx_pkg::RX_IDLE |=> rs_r == uart_rx_pkg::RX_IDLE)
        else $error("receiver left idle in mode 0");
    chk_reset_any: assert property (@(posedge clk_sys) // R13
        rst |=> receive_station_address_r == 8'h00 && smask_r == 8'h00 && addr_match)
        else $error("reset address not open");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        irq == |(irq_st_r & irq_mk_r))
        else $error("interrupt level mismatch");
endmodule : uart_rx_filter

/* File: serial_peer.sv */
// Purpose: Far serial node that drives frames into the port and listens to its transmit line.
// Assumes: BIT_CLKS clk_sys cycles per bit, the same as the port's baud setting.
// Notes: The line idles high between frames; frames are started by the bench.
`timescale 1ns/100ps
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_sys,
    output logic to_port,
    input wire logic from_port,
    output logic in_stop,
    output logic [7:0] heard_byte,
    output logic [7:0] heard_count
);
    // Bit length used when listening; the bench may change it to follow the port's transmit rate.
    int hear_clks;
    // Sends start, data LSB first, an optional ninth bit and the chosen stop level, then one idle bit.
    task automatic send_frame(input logic [7:0] d, input logic has9, input logic b9, input logic stop);
        logic [10:0] bits;
        int n;
        n = has9 ? 11 : 10;
        bits = has9 ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < n; i++) begin
            to_port <= bits[i];
            in_stop <= (i == n - 1);
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
        to_port <= 1'b1;
        in_stop <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_sys);
    endtask : send_frame

    // Samples the port's transmit line at mid bit and keeps the last byte heard.
    initial begin
        to_port = 1'b1;
        in_stop = 1'b0;
        heard_byte = 8'h00;
        heard_count = 8'h00;
        hear_clks = BIT_CLKS;
        forever begin
            @(negedge from_port);
            repeat (hear_clks / 2) @(posedge clk_sys);
            if (from_port == 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (hear_clks) @(posedge clk_sys);
                    heard_byte[i] = from_port;
                end
                heard_count = heard_count + 8'h01;
                repeat (hear_clks) @(posedge clk_sys);
            end
        end
    end
endmodule : serial_peer

/* File: tb.sv */
// Purpose: Self-checking bench for the serial receive filter.
// Assumes: Baud divider written to 0, so one bit lasts 16 clk_sys cycles.
// Notes: Register accesses leave one idle cycle between strobes.
`timescale 1ns/100ps
`include "uart_rx_defs.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic clk_sys = 1'b0;
    logic rst;
    uart_rx_pkg::reg_req_t req;
    logic [7:0] reg_rdata;
    logic rx_line;
    logic tx_line;
    logic irq;
    logic in_stop;
    logic [7:0] heard_byte;
    logic [7:0] heard_count;
    logic [7:0] rd;
    logic rb8_exp;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] zero_regs [8] = '{`OFS_SERIAL_CONTROL, `OFS_POWER_CONTROL, `OFS_STATION_ADDRESS,
        `OFS_ADDRESS_MASK, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_RX_DATA, 8'h10};
    // Each row: control, station, mask, address sent, stop level, receive done expected.
    logic [47:0] rows [11] = '{48'hF0_00_00_3C_01_01, 48'hF0_56_FC_57_01_01, 48'hF0_56_FC_66_01_00,
        48'hF0_56_FC_FE_01_01, 48'hF0_56_FF_57_01_00, 48'hF0_56_FF_56_01_01, 48'hB0_56_FC_66_01_00,
        48'hD0_56_FF_66_01_01, 48'h70_56_FF_56_00_00, 48'h70_56_FF_56_01_01, 48'h30_56_FF_56_01_00};

    // Clock of 50 ns period.
    always #25 clk_sys = ~clk_sys;

    uart_rx_filter uut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr),
        .reg_rd(req.rd), .reg_rdata(reg_rdata), .rx_pin(rx_line), .tx_pin(tx_line), .irq(irq)
    );

    serial_peer #(.BIT_CLKS(16)) peer (
        .clk_sys(clk_sys), .to_port(rx_line), .from_port(tx_line), .in_stop(in_stop),
        .heard_byte(heard_byte), .heard_count(heard_count)
    );

    // One-cycle write strobe followed by an idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
    endtask : wr

    // One-cycle read strobe; data are taken in the following cycle only.
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rdr

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Main sequence of register calls and frames.
    initial begin
        rst = 1'b1;
        req = '0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (zero_regs[i]) begin
            rdr(zero_regs[i], rd);
            `CHK("reset value", 8'h00, rd)
        end
        wr(`OFS_BAUD_DIV, 8'h00);
        wr(`OFS_TX_BAUD_DIV, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_POWER_CONTROL, 8'h40);
        wr(`OFS_SERIAL_CONTROL, 8'h50);
        fork
            peer.send_frame(8'hA5, 1'b0, 1'b0, 1'b0);
            begin
                @(posedge in_stop);
                repeat (2) @(posedge clk_sys);
                rdr(`OFS_SERIAL_CONTROL, rd);
                `CHK("done before stop", 1'b0, rd[0])
            end
        join
        rdr(`OFS_SERIAL_CONTROL, rd);
        `CHK("frame error", 1'b1, rd[7])
        `CHK("done at stop", 1'b1, rd[0])
        `CHK("interrupt", 1'b1, irq)
        rdr(`OFS_RX_DATA, rd);
        `CHK("data", 8'hA5, rd)
        peer.send_frame(8'h3C, 1'b0, 1'b0, 1'b1);
        rdr(`OFS_SERIAL_CONTROL, rd);
        `CHK("sticky error", 1'b1, rd[7])
        wr(`OFS_SERIAL_CONTROL, 8'h50);
        wr(`OFS_IRQ_STATUS, 8'h07);
        rdr(`OFS_SERIAL_CONTROL, rd);
        `CHK("error cleared", 8'h54, rd)
        `CHK("interrupt off", 1'b0, irq)
        wr(`OFS_POWER_CONTROL, 8'h00);
        peer.send_frame(8'h0F, 1'b0, 1'b0, 1'b0);
        wr(`OFS_POWER_CONTROL, 8'h40);
        rdr(`OFS_SERIAL_CONTROL, rd);
        `CHK("check disabled", 1'b0, rd[7])
        wr(`OFS_POWER_CONTROL, 8'h00);
        wr(`OFS_IRQ_STATUS, 8'h07);
        rb8_exp = 1'b0;
        foreach (rows[i]) begin
            wr(`OFS_STATION_ADDRESS, rows[i][39:32]);
            wr(`OFS_ADDRESS_MASK, rows[i][31:24]);
            wr(`OFS_SERIAL_CONTROL, rows[i][47:40]);
            rdr(`OFS_SERIAL_CONTROL, rd);
            `CHK("control readback", rows[i][47:40] | (rb8_exp ? 8'h04 : 8'h00), rd)
            peer.send_frame(rows[i][23:16], rows[i][47], 1'b1, rows[i][8]);
            rdr(`OFS_SERIAL_CONTROL, rd);
            `CHK("address filter", rows[i][0], rd[0])
            `CHK("filter interrupt", rows[i][0], irq)
            if (rows[i][0]) begin
                rdr(`OFS_RX_DATA, rd);
                `CHK("address data", rows[i][23:16], rd)
                rb8_exp = rows[i][47] | rows[i][8];
            end
            wr(`OFS_IRQ_STATUS, 8'h01);
            wr(`OFS_SERIAL_CONTROL, 8'h00);
        end
        wr(`OFS_IRQ_MASK, 8'h00);
        wr(`OFS_SERIAL_CONTROL, 8'h50);
        fork
            wr(`OFS_TX_DATA, 8'h9C);
            peer.send_frame(8'h42, 1'b0, 1'b0, 1'b1);
        join
        repeat (40) @(posedge clk_sys);
        `CHK("masked interrupt", 1'b0, irq)
        rdr(`OFS_IRQ_STATUS, rd);
        `CHK("status sticky", 1'b1, rd[0])
        `CHK("byte heard", 8'h9C, heard_byte)
        `CHK("frames heard", 8'h01, heard_count)
        rdr(`OFS_RX_DATA, rd);
        `CHK("duplex data", 8'h42, rd)
        wr(`OFS_TX_BAUD_DIV, 8'h01);
        peer.hear_clks = 32;
        fork
            wr(`OFS_TX_DATA, 8'h5A);
            peer.send_frame(8'hC3, 1'b0, 1'b0, 1'b1);
        join
        repeat (200) @(posedge clk_sys);
        `CHK("slow byte heard", 8'h5A, heard_byte)
        `CHK("slow frames heard", 8'h02, heard_count)
        rdr(`OFS_RX_DATA, rd);
        `CHK("fast data", 8'hC3, rd)
        tally_and_finish();
    end
endmodule : tb
